// ---- verilog/synth_ctrl_regs.vh ----
// Behaviour
// - direction low shortens, high lengthens delay
// - strobe rise requests, fall applies step
// - chip enable low: power-down, registers reset
// - global power-down keeps register contents
// - lock indicator high while loop locked and not powered down
// - select bit picks data pin or output
// - adc clock divided, at most 400 kHz
// - temperature result is eight bits wide
// - select low frames burst, rising-edge sampling
// - three-wire default; output released when deselected
`ifndef SYNTH_CTRL_REGS_VH
`define SYNTH_CTRL_REGS_VH
`define CLK_FREQ_HZ 50000000
`define ADC_CLK_MAX_HZ 400000
`define ADC_DIV_IN_MAX_HZ 125000000
`define ADC_DIV_CYCLES ((`CLK_FREQ_HZ + `ADC_CLK_MAX_HZ - 1) / `ADC_CLK_MAX_HZ)
`define TEMP_BITS 8
`define DELAY_BITS 12
`define DELAY_RESET 12'h800
`define CFG_BITS 8
`define CFG_RESET 8'h00
`define CFG_FOUR_WIRE 0
`define CFG_GLOBAL_PD 1
`define SER_ADDR_CFG 7'h00
`define SER_ADDR_TEMP 7'h01
`define SER_ADDR_DELAY 7'h02
`endif

// ---- verilog/temp_adc_sampler.v ----
`timescale 1ns/10ps
`include "synth_ctrl_regs.vh"
module temp_adc_sampler #(
	parameter DIV_CYCLES = `ADC_DIV_CYCLES,
	parameter TEMP_W = `TEMP_BITS
) (
	input wire clk_in,
	input wire rst_in,
	input wire enable_in,
	input wire [TEMP_W-1:0] sample_in,
	output reg [TEMP_W-1:0] result_out
);
	reg [15:0] div_q;
	localparam [31:0] DIV_LAST = DIV_CYCLES - 1;
	wire adc_tick = ({16'h0000, div_q} == DIV_LAST);
	// with the default DIV_CYCLES the divider enable pulse never exceeds the adc clock ceiling
	always @(posedge clk_in) begin
		if (rst_in || !enable_in) begin
			div_q <= 16'h0000;
		end else if (adc_tick) begin
			div_q <= 16'h0000;
		end else begin
			div_q <= div_q + 16'h0001;
		end
	end
	// eight-bit conversion result held between conversions
	always @(posedge clk_in) begin
		if (rst_in) begin
			result_out <= {TEMP_W{1'b0}};
		end else if (enable_in && adc_tick) begin
			result_out <= sample_in;
		end
	end
endmodule

// ---- verilog/synth_ctrl.v ----
`timescale 1ns/10ps
`include "synth_ctrl_regs.vh"
module synth_ctrl #(
	parameter DELAY_W = `DELAY_BITS,
	parameter ADC_DIV = `ADC_DIV_CYCLES
) (
	// clock and reset
	input wire MCLK_IN,
	input wire SYS_RST_IN,
	// chip enable
	input wire CHIP_ENABLE_IN,
	// delay step pins
	input wire DELAY_DIRECTION_IN,
	input wire DELAY_STEP_STROBE_IN,
	// analog status
	input wire PLL_LOCKED_IN,
	input wire [7:0] TEMP_SAMPLE_IN,
	// serial port
	input wire SERIAL_SELECT_N_IN,
	input wire SERIAL_CLK_IN,
	input wire SERIAL_DATA_IN,
	output reg SERIAL_DATA_OUT,
	output reg SERIAL_DATA_OE_OUT,
	output reg SERIAL_OUT_OUT,
	output reg SERIAL_OUT_OE_OUT,
	// device state
	output reg LOCK_INDICATOR_OUT,
	output reg POWERED_DOWN_OUT,
	output reg [DELAY_W-1:0] DELAY_SETTING_OUT
);
	// strobe tracker states
	localparam [0:0] STB_IDLE = 1'h0;
	localparam [0:0] STB_ARMED = 1'h1;
	// serial frame states
	localparam [1:0] SER_IDLE = 2'h0;
	localparam [1:0] SER_CMD = 2'h1;
	localparam [1:0] SER_DATA = 2'h2;
	localparam [1:0] SER_DONE = 2'h3;
	// pin 0 is the shared data pin, pin 1 the separate four-wire output
	localparam PIN_COUNT = 2;

	reg strobe_q;
	reg stb_state_q;
	reg stb_state_d;
	reg [DELAY_W-1:0] delay_d;
	reg sclk_q;
	reg [1:0] ser_state_q;
	reg [1:0] ser_state_d;
	reg [`CFG_BITS-1:0] cfg_q;
	reg [`CFG_BITS-1:0] cfg_d;
	reg [4:0] bit_cnt_q;
	reg [4:0] bit_cnt_d;
	reg [15:0] shift_q;
	reg rd_q;
	reg rd_d;
	reg [7:0] rd_data_q;
	reg [7:0] rd_data_d;
	wire [PIN_COUNT-1:0] pin_data;
	wire [PIN_COUNT-1:0] pin_oe;
	wire [7:0] temp_val;

	function edge_up;
		input level;
		input prev;
		begin
			edge_up = level && !prev;
		end
	endfunction

	function edge_down;
		input level;
		input prev;
		begin
			edge_down = !level && prev;
		end
	endfunction

	function [DELAY_W-1:0] step_delay;
		input [DELAY_W-1:0] cur;
		input lengthen;
		begin
			if (lengthen) begin
				step_delay = cur + {{(DELAY_W-1){1'b0}}, 1'b1};
			end else begin
				step_delay = cur - {{(DELAY_W-1){1'b0}}, 1'b1};
			end
		end
	endfunction

	wire regs_rst = SYS_RST_IN || !CHIP_ENABLE_IN;
	wire pd = !CHIP_ENABLE_IN || cfg_q[`CFG_GLOBAL_PD];
	wire four_wire = cfg_q[`CFG_FOUR_WIRE];
	wire stb_rise = edge_up(DELAY_STEP_STROBE_IN, strobe_q);
	wire stb_fall = edge_down(DELAY_STEP_STROBE_IN, strobe_q);
	wire sclk_rise = edge_up(SERIAL_CLK_IN, sclk_q);
	wire sclk_fall = edge_down(SERIAL_CLK_IN, sclk_q);
	wire [15:0] shift_d = {shift_q[14:0], SERIAL_DATA_IN};
	// bits past the sixteenth are ignored
	wire take_bit = sclk_rise && !SERIAL_SELECT_N_IN && ser_state_q != SER_DONE;
	wire send_bit = sclk_fall && !SERIAL_SELECT_N_IN && rd_q && ser_state_q == SER_DATA;

	function [7:0] read_mux;
		input [6:0] addr;
		input [`CFG_BITS-1:0] cfg;
		input [7:0] temp;
		input [DELAY_W-1:0] dly;
		begin
			case (addr)
				`SER_ADDR_CFG: read_mux = cfg;
				`SER_ADDR_TEMP: read_mux = temp;
				`SER_ADDR_DELAY: read_mux = dly[DELAY_W-1:DELAY_W-8];
				default: read_mux = 8'h00;
			endcase
		end
	endfunction

	temp_adc_sampler #(
		.DIV_CYCLES(ADC_DIV),
		.TEMP_W(`TEMP_BITS)
	) u_adc (
		.clk_in(MCLK_IN),
		.rst_in(regs_rst),
		.enable_in(!pd),
		.sample_in(TEMP_SAMPLE_IN),
		.result_out(temp_val)
	);

	// rising edge arms, falling edge applies one step
	always @* begin
		stb_state_d = stb_state_q;
		delay_d = DELAY_SETTING_OUT;
		case (stb_state_q)
			STB_IDLE: begin
				if (stb_rise) begin
					stb_state_d = STB_ARMED;
				end
			end
			STB_ARMED: begin
				if (stb_fall) begin
					stb_state_d = STB_IDLE;
					delay_d = step_delay(DELAY_SETTING_OUT, DELAY_DIRECTION_IN);
				end
			end
			default: begin
				stb_state_d = STB_IDLE;
			end
		endcase
	end

	always @(posedge MCLK_IN) begin
		if (regs_rst) begin
			strobe_q <= 1'b0;
			stb_state_q <= STB_IDLE;
			DELAY_SETTING_OUT <= `DELAY_RESET;
		end else begin
			strobe_q <= DELAY_STEP_STROBE_IN;
			stb_state_q <= stb_state_d;
			DELAY_SETTING_OUT <= delay_d;
		end
	end

	always @(posedge MCLK_IN) begin
		if (SYS_RST_IN) begin
			LOCK_INDICATOR_OUT <= 1'b0;
			POWERED_DOWN_OUT <= 1'b1;
		end else begin
			LOCK_INDICATOR_OUT <= PLL_LOCKED_IN && !pd;
			POWERED_DOWN_OUT <= pd;
		end
	end

	wire [7:0] rd_word = read_mux(shift_d[6:0], cfg_q, temp_val, DELAY_SETTING_OUT);

	// serial frame: r/w bit, 7-bit address, 8 data bits, msb first
	always @* begin
		ser_state_d = ser_state_q;
		bit_cnt_d = bit_cnt_q;
		rd_d = rd_q;
		rd_data_d = rd_data_q;
		cfg_d = cfg_q;
		if (SERIAL_SELECT_N_IN) begin
			ser_state_d = SER_IDLE;
			bit_cnt_d = 5'h00;
			rd_d = 1'b0;
		end else begin
			case (ser_state_q)
				SER_IDLE, SER_CMD: begin
					if (sclk_rise) begin
						bit_cnt_d = bit_cnt_q + 5'h01;
						ser_state_d = SER_CMD;
						if (bit_cnt_q == 5'h07) begin
							ser_state_d = SER_DATA;
							rd_d = shift_d[7];
							rd_data_d = rd_word;
						end
					end
				end
				SER_DATA: begin
					if (sclk_rise) begin
						bit_cnt_d = bit_cnt_q + 5'h01;
						if (bit_cnt_q == 5'h0F) begin
							ser_state_d = SER_DONE;
							if (!shift_q[14] && shift_q[13:7] == `SER_ADDR_CFG) begin
								cfg_d = shift_d[7:0];
							end
						end
					end
					if (send_bit) begin
						rd_data_d = {rd_data_q[6:0], 1'b0};
					end
				end
				SER_DONE: begin
					ser_state_d = SER_DONE;
				end
				default: begin
					ser_state_d = SER_IDLE;
				end
			endcase
		end
	end

	always @(posedge MCLK_IN) begin
		if (regs_rst) begin
			sclk_q <= 1'b0;
			ser_state_q <= SER_IDLE;
			cfg_q <= `CFG_RESET;
			bit_cnt_q <= 5'h00;
			shift_q <= 16'h0000;
			rd_q <= 1'b0;
			rd_data_q <= 8'h00;
		end else begin
			sclk_q <= SERIAL_CLK_IN;
			ser_state_q <= ser_state_d;
			cfg_q <= cfg_d;
			bit_cnt_q <= bit_cnt_d;
			rd_q <= rd_d;
			rd_data_q <= rd_data_d;
			if (take_bit) begin
				shift_q <= shift_d;
			end
		end
	end

	// one read-data driver per pin; only the pin picked by the mode bit drives
	genvar pin;
	generate
		for (pin = 0; pin < PIN_COUNT; pin = pin + 1) begin : g_pin
			reg data_q;
			reg oe_q;
			wire chosen = (pin == 1) ? four_wire : !four_wire;
			always @(posedge MCLK_IN) begin
				if (regs_rst) begin
					data_q <= 1'b0;
					oe_q <= 1'b0;
				end else if (SERIAL_SELECT_N_IN) begin
					oe_q <= 1'b0;
				end else if (send_bit && chosen) begin
					data_q <= rd_data_q[7];
					oe_q <= 1'b1;
				end
			end
			assign pin_data[pin] = data_q;
			assign pin_oe[pin] = oe_q;
		end
	endgenerate

	// pins come straight from the per-pin flip-flops
	always @* begin
		SERIAL_DATA_OUT = pin_data[0];
		SERIAL_DATA_OE_OUT = pin_oe[0];
		SERIAL_OUT_OUT = pin_data[1];
		SERIAL_OUT_OE_OUT = pin_oe[1];
	end
endmodule

// ---- test/synth_ctrl_checker.sv ----
`timescale 1ns/10ps
module synth_ctrl_checker(input wire MCLK_IN,SYS_RST_IN,CHIP_ENABLE_IN,PLL_LOCKED_IN,
	DELAY_DIRECTION_IN,DELAY_STEP_STROBE_IN,SERIAL_SELECT_N_IN,SERIAL_DATA_OE_OUT,
	SERIAL_OUT_OE_OUT,LOCK_INDICATOR_OUT,POWERED_DOWN_OUT,input wire [11:0] DELAY_SETTING_OUT);
	wire c=CHIP_ENABLE_IN,s=DELAY_STEP_STROBE_IN,p=PLL_LOCKED_IN,pd=POWERED_DOWN_OUT;
	wire [11:0] d=DELAY_SETTING_OUT;
	default clocking @(posedge MCLK_IN); endclocking
	default disable iff SYS_RST_IN;
	step_up_a: assert property ($fell(s)&&c&&DELAY_DIRECTION_IN|=>d==$past(d)+12'h001)
		else $error("step up");
	step_down_a: assert property ($fell(s)&&c&&!DELAY_DIRECTION_IN|=>d==$past(d)-12'h001)
		else $error("step down");
	no_step_a: assert property (c&&!$fell(s)|=>$stable(d)) else $error("stray step");
	ce_reset_a: assert property (!c|=>d==12'h800&&pd) else $error("ce");
	lock_low_a: assert property (!p||!c|=>!LOCK_INDICATOR_OUT) else $error("lock");
	lock_high_a: assert property (p&&c&&!pd ##1 !pd|->LOCK_INDICATOR_OUT)
		else $error("lock high");
	out_release_a: assert property (SERIAL_SELECT_N_IN[*3]|->!SERIAL_OUT_OE_OUT)
		else $error("release");
	data_release_a: assert property (SERIAL_SELECT_N_IN[*3]|->!SERIAL_DATA_OE_OUT)
		else $error("data release");
	one_pin_a: assert property (!(SERIAL_OUT_OE_OUT&&SERIAL_DATA_OE_OUT)) else $error("pins");
endmodule

// ---- test/host_model.sv ----
`timescale 1ns/10ps
module host_model(input wire clk,d3,e3,d4,e4,output reg cs_n=1,sck=0,sdi=0,stb=0,dir=0);
	// msb first, each sclk half lasts 3 clk; q gets pin flag and read byte
	task frame(input [15:0] f,output [8:0] q);
		integer i;
		cs_n=0;
		for(i=15;i>=0;i=i-1) begin
			sdi=f[i];
			repeat(3) @(negedge clk);
			if(i<8) q={e4,q[6:0],e4?d4:e3?d3:1'bz};
			sck=1;
			repeat(3) @(negedge clk);
			sck=0;
		end
		repeat(3) @(negedge clk);
		cs_n=1;
		sdi=~sdi;
		repeat(3) @(negedge clk);
	endtask
	task strobe_up(input d);
		dir=d;
		@(negedge clk) stb=1;
	endtask
	task strobe_down;
		stb=0;
		repeat(2) @(negedge clk);
	endtask
	task step(input d);
		strobe_up(d);
		repeat(2) @(negedge clk);
		strobe_down;
	endtask
endmodule

// ---- test/synth_control_pins_delay_step_test.sv ----
`timescale 1ns/10ps
module synth_control_pins_delay_step_test;
	reg clk=0,rst=1,ce=1,lk=0;
	wire cs_n,sck,sdi,stb,dir,d3,e3,d4,e4,lko,pdo;
	wire [11:0] dly;
	reg [8:0] q;
	reg [7:0] tmp=8'h5A;
	integer num_errors=0,n_compared=0,cyc=0;
	always #10 clk=~clk;
	synth_ctrl #(.ADC_DIV(4)) synth_ctrl_i(.MCLK_IN(clk),.SYS_RST_IN(rst),.CHIP_ENABLE_IN(ce),
		.DELAY_DIRECTION_IN(dir),.DELAY_STEP_STROBE_IN(stb),.PLL_LOCKED_IN(lk),
		.TEMP_SAMPLE_IN(tmp),.SERIAL_SELECT_N_IN(cs_n),.SERIAL_CLK_IN(sck),
		.SERIAL_DATA_IN(e3?d3:sdi),.SERIAL_DATA_OUT(d3),.SERIAL_DATA_OE_OUT(e3),
		.SERIAL_OUT_OUT(d4),.SERIAL_OUT_OE_OUT(e4),.LOCK_INDICATOR_OUT(lko),
		.POWERED_DOWN_OUT(pdo),.DELAY_SETTING_OUT(dly));
	host_model host_model_i(.clk(clk),.d3(d3),.e3(e3),.d4(d4),.e4(e4),.cs_n(cs_n),
		.sck(sck),.sdi(sdi),.stb(stb),.dir(dir));
	task chk(input [31:0] nm,input [11:0] e,v);
		n_compared=n_compared+1;
		if(v!==e) begin
			num_errors=num_errors+1;
			$display("BAD %s exp %h got %h",nm,e,v);
		end
	endtask
	task tally_and_finish;
		$display("errors %0d compared %0d",num_errors,n_compared);
		if(num_errors==0&&n_compared>0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task t_step;
		chk("dly",12'h800,dly);
		host_model_i.step(1);
		host_model_i.step(1);
		host_model_i.step(0);
		chk("dly",12'h801,dly);
		host_model_i.strobe_up(1);
		repeat(3) @(negedge clk);
		chk("dly",12'h801,dly);
		host_model_i.strobe_down;
		chk("dly",12'h802,dly);
	endtask
	task t_lock;
		lk=1;
		repeat(2) @(negedge clk);
		chk("lock",1,lko);
		lk=0;
		@(negedge clk) chk("lock",0,lko);
	endtask
	task t_pd;
		host_model_i.frame(16'h0002,q);
		chk("pd",1,pdo);
		lk=1;
		repeat(2) @(negedge clk);
		chk("lock",0,lko);
		lk=0;
		host_model_i.frame(16'h8000,q);
		chk("rd",9'h002,q);
		host_model_i.frame(16'h0001,q);
		chk("dly",12'h802,dly);
		host_model_i.frame(16'h8100,q);
		chk("rd",9'h15A,q);
		tmp=8'hA5;
		host_model_i.frame(16'h8100,q);
		chk("rd",9'h1A5,q);
		chk("pd",0,pdo);
	endtask
	task t_ce;
		ce=0;
		repeat(2) @(negedge clk);
		chk("pd",1,pdo);
		ce=1;
		host_model_i.frame(16'h8000,q);
		chk("rd",9'h000,q);
		chk("dly",12'h800,dly);
	endtask
	always @(posedge clk) begin
		cyc=cyc+1;
		if(cyc==5000) begin
			num_errors=num_errors+1;
			tally_and_finish;
		end
	end
	initial begin
		repeat(4) @(negedge clk);
		rst=0;
		t_step;
		t_lock;
		t_pd;
		t_ce;
		tally_and_finish;
	end
endmodule
bind synth_ctrl synth_ctrl_checker synth_ctrl_checker_i(.MCLK_IN(MCLK_IN),.SYS_RST_IN(SYS_RST_IN),
	.CHIP_ENABLE_IN(CHIP_ENABLE_IN),.PLL_LOCKED_IN(PLL_LOCKED_IN),
	.DELAY_DIRECTION_IN(DELAY_DIRECTION_IN),.DELAY_STEP_STROBE_IN(DELAY_STEP_STROBE_IN),
	.SERIAL_SELECT_N_IN(SERIAL_SELECT_N_IN),.SERIAL_DATA_OE_OUT(SERIAL_DATA_OE_OUT),
	.SERIAL_OUT_OE_OUT(SERIAL_OUT_OE_OUT),.LOCK_INDICATOR_OUT(LOCK_INDICATOR_OUT),
	.POWERED_DOWN_OUT(POWERED_DOWN_OUT),.DELAY_SETTING_OUT(DELAY_SETTING_OUT));
